// ==== rtl/sq_multiframe_regs.svh ====
/*
 Register indices, field positions, reset values and frame counts of the
 multiframe channel. Assumes inclusion by its bare name from the design files.
*/
// Functional notes
// - Multiframing off: NT Fa always zero.
// - NT M bit one in frame 1 of 20.
// - NT Fa one in frames 1,6,11,16.
// - NT S bit cycles SC1..SC5 each frame.
// - TE sends Q1..Q4 in Fa frames 1,6,11,16.
// - Start bit forces M one next frame.
// - TE detects multiframe, sets detected flag.
// - SC1..SC5 from tx_signal, subchannel_23, subchannel_45 nibbles.
// - NT samples sources once per multiframe.
// - NT, multiframing off: sources ignored, Fa zero.
// - NT source registers reset to zeros.
// - NT interrupt: off, Q change, or every multiframe.
// - NT loads received Q nibble per multiframe.
// - TE samples Q nibble once per multiframe.
// - TE, multiframing off: Fa wraps received Fa.
// - TE Q source nibble resets to ones.
// - TE interrupt: off, SC1 change, or every multiframe.
// - TE stores received SC1..SC5 per multiframe.
// - NT sets far-end violation status, optional interrupt.
// - Enabled pending status drives irq_n low.
`ifndef SQ_MULTIFRAME_REGS_SVH
`define SQ_MULTIFRAME_REGS_SVH

`define ADDR_TX_SIGNAL    5'h02
`define ADDR_RX_SIGNAL    5'h03
`define ADDR_CONTROL7     5'h07
`define ADDR_SUBCH_23     5'h09
`define ADDR_SUBCH_45     5'h0A
`define ADDR_NIB_DETECT   5'h11
`define ADDR_NIB_STATUS   5'h13
`define ADDR_NIB_ENABLE   5'h14

`define BIT_MF_START      5
`define BIT_IRQ_EVERY     2
`define BIT_MF_DETECT     1
`define BIT_CV            1
`define BIT_MF            2

`define NT_SRC_RESET      8'h00
`define TE_Q_RESET        4'hF
`define INIT_LOAD_COUNT   2'h3

`define SUB_LAST          3'h4
`define GRP_LAST          2'h3

`define RX_FIFO_WIDTH     4
`define RX_FIFO_DEPTH     4
`define W_FA              0
`define W_M               1
`define W_S               2
`define W_CV              3

`endif

// ==== rtl/sq_multiframe_pkg.sv ====
/*
 Types shared by the multiframe channel. Assumes nothing of its surroundings.
*/
package sq_multiframe_pkg;
   typedef enum logic [1:0] {
      SYNC_HUNT = 2'b01,
      SYNC_LOCK = 2'b10
   } sync_e;
   typedef logic [3:0] nibble_t;
endpackage : sq_multiframe_pkg

// ==== rtl/sq_multiframe_channel.sv ====
/*
 Layer 1 multiframe channel: a small receive FIFO and the multiframe logic
 for NT and TE modes with its byte and nibble registers.
 Assumes frame bits arrive from line logic on clk, one word per frame, and
 that frame_tick pulses once at each transmit frame boundary.
*/
`timescale 1ns/10ps
`include "sq_multiframe_regs.svh"

module sq_rx_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;
   assign in_ready  = (count != CW'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_count = CW'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = CW'(count - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage needs no reset; empty entries are never presented.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : sq_rx_fifo

module sq_multiframe_channel (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       nt_mode_pin,
   input  wire logic       frame_tick,
   input  wire logic       rx_valid,
   output logic            rx_ready,
   input  wire logic [3:0] rx_word,
   output logic            tx_fa,
   output logic            tx_m,
   output logic            tx_s,
   input  wire logic [4:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   output logic            irq_n
);
   // -------------------------------------------------------------
   // Mode strap and receive buffer
   // -------------------------------------------------------------
   logic       nt_meta;
   logic       nt_mode;
   logic       f_valid;
   logic       f_ready;
   logic [3:0] f_word;
   logic       pop;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {nt_mode, nt_meta} <= 2'h0;
      end else begin
         {nt_mode, nt_meta} <= {nt_meta, nt_mode_pin};
      end
   end

   // Register writes stall the drain so a capture never meets a write.
   assign f_ready = !reg_wr;
   assign pop     = f_valid & f_ready;
   sq_rx_fifo #(
      .WIDTH (`RX_FIFO_WIDTH),
      .DEPTH (`RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   (rx_word),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_word)
   );

   // -------------------------------------------------------------
   // Registers and receive multiframe
   // -------------------------------------------------------------
   sq_multiframe_pkg::sync_e   sync;
   sq_multiframe_pkg::sync_e   next_sync;
   sq_multiframe_pkg::nibble_t acc [5];
   sq_multiframe_pkg::nibble_t next_acc [5];
   logic [7:0] tx_sig, rx_sig, ctl7, sc23, sc45;
   logic [7:0] next_tx_sig, next_rx_sig, next_ctl7, next_sc23, next_sc45;
   logic [7:0] next_rdata;
   logic [2:0] rsub, next_rsub;
   logic [1:0] rgrp, next_rgrp;
   logic [1:0] init_cnt, next_init_cnt;
   logic       cv_acc, next_cv_acc;
   logic       cv_st, next_cv_st, mf_st, next_mf_st;
   logic       cv_en, next_cv_en, mf_en, next_mf_en;
   logic       start_rise;
   logic       rx_take;
   logic       rx_end;
   logic       changed;
   logic [2:0] esub;
   logic [1:0] egrp;
   assign start_rise = reg_wr && reg_addr == `ADDR_CONTROL7 && nt_mode &&
                       reg_wdata[`BIT_MF_START] && !ctl7[`BIT_MF_START];
   always_comb begin
      next_sync     = sync;
      next_tx_sig   = tx_sig;
      next_rx_sig   = rx_sig;
      next_ctl7     = ctl7;
      next_sc23     = sc23;
      next_sc45     = sc45;
      next_rsub     = rsub;
      next_rgrp     = rgrp;
      next_cv_acc   = cv_acc;
      next_cv_st    = cv_st;
      next_mf_st    = mf_st;
      next_cv_en    = cv_en;
      next_mf_en    = mf_en;
      next_init_cnt = init_cnt;
      next_rdata    = reg_rdata;
      changed       = 1'b0;
      rx_end        = 1'b0;
      next_acc      = acc;
      // The strap is only settled after the synchroniser has filled.
      if (init_cnt != `INIT_LOAD_COUNT) begin
         next_init_cnt = 2'(init_cnt + 1'b1);
      end
      if (init_cnt == 2'(`INIT_LOAD_COUNT - 1'b1) && !nt_mode) begin
         next_tx_sig[7:4] = `TE_Q_RESET;
      end
      // Software writes land first so that hardware sets below win.
      if (reg_wr) begin
         if (reg_addr == `ADDR_TX_SIGNAL) begin
            next_tx_sig = reg_wdata;
         end else if (reg_addr == `ADDR_RX_SIGNAL) begin
            next_rx_sig[3:0] = reg_wdata[3:0];
         end else if (reg_addr == `ADDR_CONTROL7) begin
            next_ctl7 = reg_wdata;
         end else if (reg_addr == `ADDR_SUBCH_23 && nt_mode) begin
            next_sc23 = reg_wdata;
         end else if (reg_addr == `ADDR_SUBCH_45 && nt_mode) begin
            next_sc45 = reg_wdata;
         end else if (reg_addr == `ADDR_NIB_STATUS) begin
            next_cv_st = cv_st & reg_wdata[`BIT_CV];
            next_mf_st = mf_st & reg_wdata[`BIT_MF];
         end else if (reg_addr == `ADDR_NIB_ENABLE) begin
            next_cv_en = reg_wdata[`BIT_CV];
            next_mf_en = reg_wdata[`BIT_MF];
         end
      end
      if (reg_rd) begin
         if (reg_addr == `ADDR_TX_SIGNAL) begin
            next_rdata = tx_sig;
         end else if (reg_addr == `ADDR_RX_SIGNAL) begin
            next_rdata = rx_sig;
         end else if (reg_addr == `ADDR_CONTROL7) begin
            next_rdata = ctl7;
         end else if (reg_addr == `ADDR_SUBCH_23) begin
            next_rdata = sc23;
         end else if (reg_addr == `ADDR_SUBCH_45) begin
            next_rdata = sc45;
         end else if (reg_addr == `ADDR_NIB_DETECT) begin
            next_rdata = {6'h00, sync == sq_multiframe_pkg::SYNC_LOCK, 1'b0};
         end else if (reg_addr == `ADDR_NIB_STATUS) begin
            next_rdata = {5'h00, mf_st, cv_st, 1'b0};
         end else if (reg_addr == `ADDR_NIB_ENABLE) begin
            next_rdata = {5'h00, mf_en, cv_en, 1'b0};
         end else begin
            next_rdata = 8'h00;
         end
      end
      // An incoming M bit always marks frame 1 and (re)locks.
      esub    = f_word[`W_M] ? 3'h0 : rsub;
      egrp    = f_word[`W_M] ? 2'h0 : rgrp;
      rx_take = pop && (f_word[`W_M] || sync == sq_multiframe_pkg::SYNC_LOCK);
      if (pop && f_word[`W_M]) begin
         next_sync = sq_multiframe_pkg::SYNC_LOCK;
      end else if (pop && sync == sq_multiframe_pkg::SYNC_LOCK && esub == 3'h0 &&
                   egrp == 2'h0) begin
         // Frame 1 expected without its M bit: the structure is gone.
         next_sync = sq_multiframe_pkg::SYNC_HUNT;
         rx_take   = 1'b0;
      end
      if (rx_take) begin
         if (nt_mode) begin
            if (esub == 3'h0) begin
               next_acc[0][~egrp] = f_word[`W_FA];
            end
            next_cv_acc = cv_acc | f_word[`W_CV];
         end else begin
            next_acc[esub][~egrp] = f_word[`W_S];
         end
         rx_end = (esub == `SUB_LAST) && (egrp == `GRP_LAST);
         if (rx_end) begin
            next_rsub = 3'h0;
            next_rgrp = 2'h0;
         end else if (esub == `SUB_LAST) begin
            next_rsub = 3'h0;
            next_rgrp = 2'(egrp + 1'b1);
         end else begin
            next_rsub = 3'(esub + 1'b1);
            next_rgrp = egrp;
         end
      end
      if (rx_end) begin
         changed          = next_acc[0] != rx_sig[7:4];
         next_rx_sig[7:4] = next_acc[0];
         if (rx_sig[`BIT_IRQ_EVERY] || changed) begin
            next_mf_st = 1'b1;
         end
         if (nt_mode) begin
            next_cv_st  = next_cv_st | next_cv_acc;
            next_cv_acc = 1'b0;
         end else begin
            next_sc23 = {next_acc[1], next_acc[2]};
            next_sc45 = {next_acc[3], next_acc[4]};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync      <= sq_multiframe_pkg::SYNC_HUNT;
         tx_sig    <= `NT_SRC_RESET;
         rx_sig    <= 8'h00;
         ctl7      <= 8'h00;
         sc23      <= `NT_SRC_RESET;
         sc45      <= `NT_SRC_RESET;
         rsub      <= 3'h0;
         rgrp      <= 2'h0;
         cv_acc    <= 1'b0;
         cv_st     <= 1'b0;
         mf_st     <= 1'b0;
         cv_en     <= 1'b0;
         mf_en     <= 1'b0;
         init_cnt  <= 2'h0;
         reg_rdata <= 8'h00;
         acc       <= '{default: 4'h0};
      end else begin
         sync      <= next_sync;
         tx_sig    <= next_tx_sig;
         rx_sig    <= next_rx_sig;
         ctl7      <= next_ctl7;
         sc23      <= next_sc23;
         sc45      <= next_sc45;
         rsub      <= next_rsub;
         rgrp      <= next_rgrp;
         cv_acc    <= next_cv_acc;
         cv_st     <= next_cv_st;
         mf_st     <= next_mf_st;
         cv_en     <= next_cv_en;
         mf_en     <= next_mf_en;
         init_cnt  <= next_init_cnt;
         reg_rdata <= next_rdata;
         acc       <= next_acc;
      end
   end
   assign irq_n = !((mf_st & mf_en) | (cv_st & cv_en));

   // -------------------------------------------------------------
   // Transmit multiframe
   // -------------------------------------------------------------
   sq_multiframe_pkg::nibble_t src [5];
   sq_multiframe_pkg::nibble_t sh [5];
   sq_multiframe_pkg::nibble_t next_sh [5];
   sq_multiframe_pkg::nibble_t cur;
   logic [2:0] tsub, next_tsub;
   logic [1:0] tgrp, next_tgrp;
   logic       last_fa, next_last_fa;
   logic       next_tx_fa, next_tx_m, next_tx_s;
   logic       tp0;
   logic       mf_on;
   assign src[0] = tx_sig[7:4];
   assign src[1] = sc23[7:4];
   assign src[2] = sc23[3:0];
   assign src[3] = sc45[7:4];
   assign src[4] = sc45[3:0];
   assign tp0    = (tsub == 3'h0) && (tgrp == 2'h0);
   assign mf_on  = ctl7[`BIT_MF_START];
   always_comb begin
      next_tsub    = tsub;
      next_tgrp    = tgrp;
      next_last_fa = last_fa;
      next_tx_fa   = tx_fa;
      next_tx_m    = tx_m;
      next_tx_s    = tx_s;
      cur          = 4'h0;
      next_sh      = sh;
      if (pop) begin
         next_last_fa = f_word[`W_FA];
      end
      if (frame_tick) begin
         // Sources are frozen at frame 1 so a mid-multiframe write waits.
         if (tp0) begin
            next_sh = src;
         end
         cur = tp0 ? src[tsub] : sh[tsub];
         if (nt_mode) begin
            next_tx_fa = mf_on && tsub == 3'h0;
            next_tx_m  = mf_on && tp0;
            next_tx_s  = mf_on && cur[~tgrp];
         end else begin
            next_tx_m = 1'b0;
            next_tx_s = 1'b0;
            if (sync == sq_multiframe_pkg::SYNC_LOCK) begin
               next_tx_fa = (tsub == 3'h0) && cur[~tgrp];
            end else begin
               next_tx_fa = last_fa;
            end
         end
         if (tsub == `SUB_LAST) begin
            next_tsub = 3'h0;
            next_tgrp = 2'(tgrp + 1'b1);
         end else begin
            next_tsub = 3'(tsub + 1'b1);
         end
      end
      if (start_rise) begin
         next_tsub = 3'h0;
         next_tgrp = 2'h0;
      end else if (!nt_mode && pop && f_word[`W_M]) begin
         // A TE answers in step with the frame that carried the M bit.
         next_tsub = 3'h1;
         next_tgrp = 2'h0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tsub    <= 3'h0;
         tgrp    <= 2'h0;
         last_fa <= 1'b0;
         tx_fa   <= 1'b0;
         tx_m    <= 1'b0;
         tx_s    <= 1'b0;
         sh      <= '{default: 4'h0};
      end else begin
         tsub    <= next_tsub;
         tgrp    <= next_tgrp;
         last_fa <= next_last_fa;
         tx_fa   <= next_tx_fa;
         tx_m    <= next_tx_m;
         tx_s    <= next_tx_s;
         sh      <= next_sh;
      end
   end
endmodule : sq_multiframe_channel

// ==== verif/sq_multiframe_asserts.sv ====
/*
 Checker for the multiframe channel, watching only the top module's ports.
 Assumes one clock domain and a reset that is active high.
*/
`timescale 1ns/10ps
module sq_multiframe_asserts (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       nt_mode_pin,
   input wire logic       frame_tick,
   input wire logic       tx_fa,
   input wire logic       tx_m,
   input wire logic       tx_s,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       irq_n
);
   // ------------------------------------------------------------------
   // Frame gap counters
   // ------------------------------------------------------------------
   // Gaps are judged two edges after a tick, so a one or two cycle
   // output latency both pass.
   logic [1:0] tick_d;
   logic [4:0] fa_gap;
   logic [4:0] m_gap;
   logic [1:0] next_tick_d;
   logic [4:0] next_fa_gap;
   logic [4:0] next_m_gap;
   always_comb begin
      next_tick_d = {tick_d[0], frame_tick};
      next_fa_gap = fa_gap;
      next_m_gap  = m_gap;
      if (tick_d[1]) begin
         next_fa_gap = tx_fa ? 5'h01 : ((fa_gap == 5'h1F) ? fa_gap : fa_gap + 5'h01);
         next_m_gap  = tx_m ? 5'h01 : ((m_gap == 5'h00) ? m_gap : m_gap + 5'h01);
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_d <= 2'h0;
         fa_gap <= 5'h00;
         m_gap  <= 5'h00;
      end else begin
         tick_d <= next_tick_d;
         fa_gap <= next_fa_gap;
         m_gap  <= next_m_gap;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_tx_hold: assert property (
      !tick_d[0] && !tick_d[1] |-> $stable({tx_fa, tx_m, tx_s}))
      else $error("line bits changed away from a frame boundary");
   a_m_has_fa: assert property (
      tx_m |-> tx_fa)
      else $error("boundary frame without fa");
   a_fa_spacing: assert property (
      nt_mode_pin && tick_d[1] && tx_fa && !tx_m |-> fa_gap == 5'h05)
      else $error("fa frames not five apart");
   a_m_spacing: assert property (
      nt_mode_pin && tick_d[1] && tx_m |-> m_gap == 5'h00 || m_gap == 5'h14)
      else $error("m frames not twenty apart");
   a_fa_needs_mf: assert property (
      nt_mode_pin && tx_fa |-> tx_m || m_gap != 5'h00)
      else $error("fa set before multiframing");
   a_s_needs_mf: assert property (
      nt_mode_pin && tx_s |-> tx_m || m_gap != 5'h00)
      else $error("s bit sent before multiframing");
   a_te_quiet: assert property (
      !nt_mode_pin |-> !tx_m && !tx_s)
      else $error("terminal drove m or s");
   a_rdata_hold: assert property (
      !$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   c_mf_start: cover property (tx_m);
   c_irq: cover property ($fell(irq_n));
   c_te_q: cover property (!nt_mode_pin && tx_fa);
endmodule : sq_multiframe_asserts

bind sq_multiframe_channel sq_multiframe_asserts sq_multiframe_asserts_inst (
   .clk(clk),
   .rst(rst),
   .nt_mode_pin(nt_mode_pin),
   .frame_tick(frame_tick),
   .tx_fa(tx_fa),
   .tx_m(tx_m),
   .tx_s(tx_s),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .irq_n(irq_n)
);

// ==== verif/sq_remote_model.sv ====
/*
 Behavioural far-end transceiver: paces frames and offers one received
 word per frame. Assumes the bench drives its settings at falling edges.
*/
`timescale 1ns/10ps
module sq_remote_model #(
   parameter int PERIOD = 16
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        far_nt,
   input  wire logic        mf_on,
   input  wire logic [3:0]  q_nib,
   input  wire logic [19:0] sc_bits,
   input  wire logic [4:0]  cv_frame,
   input  wire logic        rx_ready,
   output logic             frame_tick,
   output logic             rx_valid,
   output logic [3:0]       rx_word,
   output logic [4:0]       frame_no
);
   // ------------------------------------------------------------------
   // Frame source
   // ------------------------------------------------------------------
   int         cnt;
   int         p;
   logic       taken;
   logic [3:0] q_hold;
   initial {frame_tick, rx_valid, rx_word} = 6'h00;
   always @(posedge clk) taken <= rx_valid && rx_ready;
   always @(negedge clk or posedge rst) begin
      if (rst) begin
         cnt = 0;
         frame_no = 5'h14;
         frame_tick = 1'b0;
         rx_valid = 1'b0;
         rx_word = 4'h0;
         q_hold = 4'hF;
      end else begin
         frame_tick = 1'b0;
         // A released word must not look valid, so it is inverted.
         if (taken) begin
            rx_valid = 1'b0;
            rx_word = ~rx_word;
         end
         cnt = cnt + 1;
         if (cnt == PERIOD) begin
            cnt = 0;
            frame_no = (frame_no == 5'h14) ? 5'h01 : frame_no + 5'h01;
            p = frame_no - 1;
            // Q is latched once per multiframe; an unaddressed terminal keeps it all ones.
            if (p == 0) q_hold = q_nib;
            frame_tick = 1'b1;
            rx_valid = 1'b1;
            rx_word[3] = (frame_no == cv_frame);
            rx_word[1] = mf_on && p == 0;
            rx_word[2] = far_nt && mf_on && sc_bits[19 - 4 * (p % 5) - p / 5];
            if (far_nt) rx_word[0] = mf_on && p % 5 == 0;
            else rx_word[0] = mf_on && p % 5 == 0 && q_hold[3 - p / 5];
         end
      end
   end
endmodule : sq_remote_model

// ==== verif/tb_top.sv ====
/*
 Register-level bench of the multiframe channel in NT then TE mode.
 Assumes the far end is the behavioural model in sq_remote_model.
*/
`timescale 1ns/10ps
`include "sq_multiframe_regs.svh"
module tb_top;
   logic        clk;
   logic        rst;
   logic        nt_mode_pin;
   logic        frame_tick;
   logic        rx_valid;
   logic        rx_ready;
   logic [3:0]  rx_word;
   logic        tx_fa;
   logic        tx_m;
   logic        tx_s;
   logic [4:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        irq_n;
   logic        far_nt;
   logic        mf_on;
   logic [3:0]  q_nib;
   logic [3:0]  qv;
   logic [19:0] sc_bits;
   logic [4:0]  cv_frame;
   logic [4:0]  frame_no;
   logic [7:0]  d;
   logic [2:0]  t;
   logic [2:0]  e;
   int          k;
   int          fails;
   int          cmp_count;
   sq_multiframe_channel sq_multiframe_channel_inst (.clk(clk), .rst(rst),
      .nt_mode_pin(nt_mode_pin), .frame_tick(frame_tick), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_word(rx_word), .tx_fa(tx_fa), .tx_m(tx_m), .tx_s(tx_s),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .irq_n(irq_n));
   sq_remote_model sq_remote_model_inst (.clk(clk), .rst(rst), .far_nt(far_nt),
      .mf_on(mf_on), .q_nib(q_nib), .sc_bits(sc_bits), .cv_frame(cv_frame),
      .rx_ready(rx_ready), .frame_tick(frame_tick), .rx_valid(rx_valid),
      .rx_word(rx_word), .frame_no(frame_no));
   initial clk = 1'b0;
   always #4 clk = ~clk;
   // ------------------------------------------------------------------
   // Access and compare tasks
   // ------------------------------------------------------------------
   task automatic results;
      if (fails == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] x,
                       input string name);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      d = reg_rdata;
      chk(name, d & m, x);
   endtask : rchk
   // Samples the line bits two edges after a tick, once they have settled.
   task automatic frame;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (frame_tick !== 1'b1 && n < 100);
      if (n >= 100) begin
         fails++;
         results();
      end
      repeat (2) @(posedge clk);
      @(negedge clk);
      t = {tx_m, tx_fa, tx_s};
      k = frame_no - 1;
   endtask : frame
   task automatic frames(input int n);
      repeat (n) frame();
   endtask : frames
   function automatic logic [2:0] nt_exp(input int j, input logic [19:0] b);
      return {j == 0, j % 5 == 0, b[19 - 4 * (j % 5) - j / 5]};
   endfunction : nt_exp
   initial begin
      {rst, nt_mode_pin, reg_addr, reg_wr, reg_rd, reg_wdata} = {2'h3, 5'h00, 2'h0, 8'h00};
      {far_nt, mf_on, q_nib, sc_bits, cv_frame, fails, cmp_count} = 0;
      mf_on = 1'b1;
      q_nib = 4'hF;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rchk(`ADDR_TX_SIGNAL, 8'hFF, 8'h00, "tx_signal reset");
      rchk(`ADDR_SUBCH_23, 8'hFF, 8'h00, "subchannel_23 reset");
      rchk(`ADDR_SUBCH_45, 8'hFF, 8'h00, "subchannel_45 reset");
      rchk(5'h1F, 8'hFF, 8'h00, "unmapped read");
      chk("rx ready", {7'h00, rx_ready}, 8'h01);
      wr(`ADDR_TX_SIGNAL, 8'hA0);
      wr(`ADDR_SUBCH_23, 8'h5C);
      wr(`ADDR_SUBCH_45, 8'h3F);
      for (int n = 0; n < 20; n++) begin
         frame();
         chk("idle line bits", {5'h00, t}, 8'h00);
      end
      wr(`ADDR_CONTROL7, 8'h20);
      // The mid-run rewrite only shows one multiframe later.
      for (int n = 0; n < 60; n++) begin
         frame();
         e = nt_exp(n % 20, n < 40 ? 20'hA5C3F : 20'hA963F);
         chk("nt line bits", {5'h00, t}, {5'h00, e});
         if (n == 20) wr(`ADDR_SUBCH_23, 8'h96);
      end
      q_nib = 4'h9;
      wr(`ADDR_NIB_ENABLE, 8'h04);
      wr(`ADDR_RX_SIGNAL, 8'h04);
      frames(40);
      rchk(`ADDR_RX_SIGNAL, 8'hF0, 8'h90, "q nibble");
      rchk(`ADDR_NIB_STATUS, 8'h04, 8'h04, "every status");
      chk("irq asserted", {7'h00, irq_n}, 8'h00);
      wr(`ADDR_NIB_STATUS, 8'h00);
      frames(21);
      rchk(`ADDR_NIB_STATUS, 8'h04, 8'h04, "every status again");
      wr(`ADDR_RX_SIGNAL, 8'h00);
      wr(`ADDR_NIB_STATUS, 8'h00);
      frames(40);
      rchk(`ADDR_NIB_STATUS, 8'h04, 8'h00, "same nibble status");
      chk("irq idle", {7'h00, irq_n}, 8'h01);
      q_nib = 4'h6;
      frames(40);
      rchk(`ADDR_NIB_STATUS, 8'h04, 8'h04, "new nibble status");
      wr(`ADDR_NIB_ENABLE, 8'h00);
      repeat (2) @(negedge clk);
      chk("irq masked", {7'h00, irq_n}, 8'h01);
      wr(`ADDR_NIB_STATUS, 8'h00);
      cv_frame = 5'h07;
      frames(40);
      rchk(`ADDR_NIB_STATUS, 8'h02, 8'h02, "violation status");
      wr(`ADDR_NIB_ENABLE, 8'h02);
      repeat (2) @(negedge clk);
      chk("violation irq", {7'h00, irq_n}, 8'h00);
      cv_frame = 5'h00;
      rst = 1'b1;
      nt_mode_pin = 1'b0;
      far_nt = 1'b1;
      mf_on = 1'b0;
      sc_bits = 20'h3C96A;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rchk(`ADDR_TX_SIGNAL, 8'hF0, 8'hF0, "q source reset");
      wr(`ADDR_SUBCH_23, 8'h55);
      rchk(`ADDR_SUBCH_23, 8'hFF, 8'h00, "te read only");
      for (int n = 0; n < 20; n++) begin
         frame();
         chk("wrapped line bits", {5'h00, t}, 8'h00);
      end
      rchk(`ADDR_NIB_DETECT, 8'h02, 8'h00, "no detect");
      mf_on = 1'b1;
      qv = 4'h5;
      wr(`ADDR_TX_SIGNAL, 8'h50);
      wr(`ADDR_NIB_ENABLE, 8'h04);
      wr(`ADDR_RX_SIGNAL, 8'h04);
      frames(40);
      rchk(`ADDR_NIB_DETECT, 8'h02, 8'h02, "detect");
      rchk(`ADDR_RX_SIGNAL, 8'hF0, 8'h30, "sc1 nibble");
      rchk(`ADDR_SUBCH_23, 8'hFF, 8'hC9, "sc2 sc3");
      rchk(`ADDR_SUBCH_45, 8'hFF, 8'h6A, "sc4 sc5");
      rchk(`ADDR_NIB_STATUS, 8'h04, 8'h04, "te status");
      chk("te irq", {7'h00, irq_n}, 8'h00);
      for (int n = 0; n < 20; n++) begin
         frame();
         e = {1'b0, k % 5 == 0 && qv[3 - k / 5], 1'b0};
         chk("q channel", {5'h00, t}, {5'h00, e});
      end
      results();
   end
endmodule : tb_top
